// >>> hw/hmt_regs.sv
// temperature, alarm-tone and sensor selection registers of the monitor
//
// Behaviour
// R01 - tone gate bit 7 resets to 1; when 0 no source sounds the tone
// R02 - aux temp, case open, aux fan, input one sound only when enabled
// R03 - chip identity reads a fixed byte; writes ignored
// R04 - bits 6..4 pick diode model per channel, only under diode sensing
// R05 - bits 3..1 pick diode or thermistor per channel, reset 0
// R06 - battery monitored only while enabled; reading updated after a cycle
// R07 - bits 7..5 are fan divisor msb; code n divides by 2 to n
// R08 - 9-bit read-only reading: high byte bits 8..1, low bit 7 is bit 0
// R09 - processor set in bank 1, auxiliary set in bank 2, at 50h..56h
// R10 - fault count field sets consecutive detections needed before alert
// R11 - config bit 1: 0 comparator mode, 1 interrupt mode
// R12 - config bit 0 set stops monitoring that channel
// R13 - writable 9-bit hysteresis limit, reset 4Bh and 0
// R14 - writable 9-bit over-temperature limit, reset 50h and 0
// R15 - reserved config bits are read-only and read zero
// R16 - bank select bits 2..0 route indices 50h..5Fh
// R17 - comparator alert sets above limit, clears below hysteresis; n+1 counts
`timescale 1ns/1ps
`include "hmt_cfg.svh"

module hmt_regs #(
	// arbitrary neutral value
	parameter logic [7:0] CHIP_IDENTITY = 8'h3C
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire hmt_pkg::hmt_bus_s bus_in,
	input wire hmt_pkg::hmt_alarm_s alarm_src_in,
	input wire hmt_pkg::hmt_sample_s [1:0] temp_sample_in,
	input wire logic [7:0] vbat_sample_in,
	input wire logic vbat_cycle_done_in,
	output logic [7:0] rdata_out,
	output logic alarm_tone_output_out,
	output logic overtemp_alert_out,
	output logic [1:0] chan_alert_out,
	output logic [1:0] chan_stop_out,
	output logic [2:0] sensor_diode_out,
	output logic [2:0] diode_model_out,
	output logic [2:0] fan_div_msb_out,
	output logic vbat_enable_out,
	output logic [7:0] vbat_reading_out
);

	// ==========================================
	// state
	hmt_pkg::hmt_state_s st_q;
	hmt_pkg::hmt_state_s st_d;

	logic [2:0] bank;
	logic win;
	logic hit;
	logic [2:0] bank_id;
	logic [2:0] cnt_new;
	logic over;
	logic below;
	logic trip;
	logic [7:0] a;

	always_comb begin
		st_d = st_q;
		bank = st_q.bank_sel[2:0];
		a = bus_in.addr;
		win = (a >= `HMT_IDX_WIN_LO) && (a <= `HMT_IDX_WIN_HI);
		hit = 1'b0;
		bank_id = `HMT_BANK_MAIN;
		cnt_new = 3'h0;
		over = 1'b0;
		below = 1'b0;
		trip = 1'b0;
		// unmapped indices and other banks read zero
		st_d.rdata = 8'h00;

		// ==========================================
		// global and bank 0 registers
		if (bus_in.rd) begin
			if (a == `HMT_IDX_BANK) begin
				st_d.rdata = st_q.bank_sel;
			end else if (win && bank == `HMT_BANK_MAIN) begin // R16
				if (a == `HMT_IDX_TONE2) begin
					st_d.rdata = st_q.tone2;
				end else if (a == `HMT_IDX_CHIPID) begin
					st_d.rdata = CHIP_IDENTITY; // R03
				end else if (a == `HMT_IDX_DIODE) begin
					st_d.rdata = st_q.diode;
				end else if (a == `HMT_IDX_BATCTL) begin
					st_d.rdata = st_q.batctl;
				end
			end
		end
		if (bus_in.wr) begin
			if (a == `HMT_IDX_BANK) begin
				st_d.bank_sel = bus_in.wdata & `HMT_MASK_BANK; // R16
			end else if (win && bank == `HMT_BANK_MAIN) begin // R16
				if (a == `HMT_IDX_TONE2) begin
					st_d.tone2 = bus_in.wdata & `HMT_MASK_TONE2; // R01 R02
				end else if (a == `HMT_IDX_DIODE) begin
					st_d.diode = bus_in.wdata & `HMT_MASK_DIODE; // R04
				end else if (a == `HMT_IDX_BATCTL) begin
					st_d.batctl = bus_in.wdata & `HMT_MASK_BATCTL; // R05 R07
				end
			end
		end

		// ==========================================
		// battery reading; the enabling write itself does not count, so the
		// first update comes on a completed cycle seen with the bit already set
		if (vbat_cycle_done_in && st_q.batctl[0]) begin
			st_d.vbat = vbat_sample_in; // R06
		end

		// ==========================================
		// remote channels, identical layout per bank
		for (int i = 0; i < 2; i++) begin
			bank_id = (i == 0) ? `HMT_BANK_CPU : `HMT_BANK_AUX;
			hit = win && (bank == bank_id); // R09
			if (bus_in.rd && hit) begin
				if (a == `HMT_IDX_T_HI) begin
					st_d.rdata = st_q.ch[i].temp[8:1]; // R08
				end else if (a == `HMT_IDX_T_LO) begin
					st_d.rdata = {st_q.ch[i].temp[0], 7'h00}; // R08
				end else if (a == `HMT_IDX_CFG) begin
					st_d.rdata = {3'h0, st_q.ch[i].fault_code, 1'b0,
						st_q.ch[i].int_mode, st_q.ch[i].stop}; // R15
					// interrupt mode: reading the config acknowledges
					if (st_q.ch[i].int_mode) begin
						st_d.ch[i].alert = 1'b0; // R11
					end
				end else if (a == `HMT_IDX_HY_HI) begin
					st_d.rdata = st_q.ch[i].hyst[8:1];
				end else if (a == `HMT_IDX_HY_LO) begin
					st_d.rdata = {st_q.ch[i].hyst[0], 7'h00};
				end else if (a == `HMT_IDX_OV_HI) begin
					st_d.rdata = st_q.ch[i].ovt[8:1];
				end else if (a == `HMT_IDX_OV_LO) begin
					st_d.rdata = {st_q.ch[i].ovt[0], 7'h00};
				end
			end
			if (bus_in.wr && hit) begin
				if (a == `HMT_IDX_CFG) begin
					st_d.ch[i].fault_code = bus_in.wdata[`HMT_FLT_HI:`HMT_FLT_LO]; // R10
					st_d.ch[i].int_mode = bus_in.wdata[`HMT_CFG_MODE]; // R11
					st_d.ch[i].stop = bus_in.wdata[`HMT_CFG_STOP]; // R12
				end else if (a == `HMT_IDX_HY_HI) begin
					st_d.ch[i].hyst[8:1] = bus_in.wdata; // R13
				end else if (a == `HMT_IDX_HY_LO) begin
					st_d.ch[i].hyst[0] = bus_in.wdata[7]; // R13
				end else if (a == `HMT_IDX_OV_HI) begin
					st_d.ch[i].ovt[8:1] = bus_in.wdata; // R14
				end else if (a == `HMT_IDX_OV_LO) begin
					st_d.ch[i].ovt[0] = bus_in.wdata[7]; // R14
				end
			end

			// samples are compared against the limits held before this cycle
			if (temp_sample_in[i].valid && !st_q.ch[i].stop) begin // R12
				st_d.ch[i].temp = temp_sample_in[i].value; // R08
				over = temp_sample_in[i].value > st_q.ch[i].ovt;
				below = temp_sample_in[i].value < st_q.ch[i].hyst;
				if (!over) begin
					cnt_new = 3'h0; // R10
				end else if (st_q.ch[i].cnt == `HMT_CNT_MAX) begin
					cnt_new = `HMT_CNT_MAX;
				end else begin
					cnt_new = st_q.ch[i].cnt + 3'h1; // R10
				end
				st_d.ch[i].cnt = cnt_new;
				trip = over && (cnt_new > {1'b0, st_q.ch[i].fault_code}); // R17
				if (!st_q.ch[i].int_mode) begin
					if (trip) begin
						st_d.ch[i].alert = 1'b1; // R17
					end else if (below) begin
						st_d.ch[i].alert = 1'b0; // R17
					end
					st_d.ch[i].armed = 1'b1;
				end else begin
					// set after the read clear, so a coincident trip survives
					if (trip && st_q.ch[i].armed) begin
						st_d.ch[i].alert = 1'b1; // R11
						st_d.ch[i].armed = 1'b0;
					end else if (below) begin
						st_d.ch[i].armed = 1'b1; // R11
					end
				end
			end
		end

		// ==========================================
		// outputs registered from next state
		st_d.ovt_any = st_d.ch[0].alert | st_d.ch[1].alert;
		// model bit means nothing for a thermistor channel, so it is masked
		st_d.model = st_d.diode[6:4] & st_d.batctl[3:1]; // R04
		st_d.tone = st_d.tone2[`HMT_TONE_GATE] & ( // R01
			(st_d.tone2[5] & alarm_src_in.aux_temp) | // R02
			(st_d.tone2[4] & alarm_src_in.case_open) | // R02
			(st_d.tone2[3] & alarm_src_in.aux_fan) | // R02
			(st_d.tone2[0] & alarm_src_in.analog_input_one)); // R02
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
			st_q.bank_sel <= `HMT_RST_BANK;
			st_q.tone2 <= `HMT_RST_TONE2; // R01
			st_q.diode <= `HMT_RST_DIODE;
			st_q.batctl <= `HMT_RST_BATCTL; // R05
			for (int i = 0; i < 2; i++) begin
				st_q.ch[i].hyst <= {`HMT_RST_HY_HI, `HMT_RST_LO}; // R13
				st_q.ch[i].ovt <= {`HMT_RST_OV_HI, `HMT_RST_LO}; // R14
				st_q.ch[i].armed <= 1'b1;
			end
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// ports
	assign rdata_out = st_q.rdata;
	assign alarm_tone_output_out = st_q.tone;
	assign overtemp_alert_out = st_q.ovt_any;
	assign chan_alert_out = {st_q.ch[1].alert, st_q.ch[0].alert};
	assign chan_stop_out = {st_q.ch[1].stop, st_q.ch[0].stop};
	assign sensor_diode_out = st_q.batctl[3:1]; // R05
	assign diode_model_out = st_q.model; // R04
	assign fan_div_msb_out = st_q.batctl[7:5]; // R07
	assign vbat_enable_out = st_q.batctl[0]; // R06
	assign vbat_reading_out = st_q.vbat;

endmodule // hmt_regs

// >>> hw/hmt_cfg.svh
// register offsets, field positions and reset values of the monitor bank
`ifndef HMT_CFG_SVH
`define HMT_CFG_SVH

// ==========================================
// index space
`define HMT_IDX_BANK 8'h4E
`define HMT_IDX_TONE2 8'h57
`define HMT_IDX_CHIPID 8'h58
`define HMT_IDX_DIODE 8'h59
`define HMT_IDX_BATCTL 8'h5D
`define HMT_IDX_T_HI 8'h50
`define HMT_IDX_T_LO 8'h51
`define HMT_IDX_CFG 8'h52
`define HMT_IDX_HY_HI 8'h53
`define HMT_IDX_HY_LO 8'h54
`define HMT_IDX_OV_HI 8'h55
`define HMT_IDX_OV_LO 8'h56
`define HMT_IDX_WIN_LO 8'h50
`define HMT_IDX_WIN_HI 8'h5F

// ==========================================
// banks
`define HMT_BANK_MAIN 3'h0
`define HMT_BANK_CPU 3'h1
`define HMT_BANK_AUX 3'h2

// ==========================================
// reset values
`define HMT_RST_BANK 8'h80
`define HMT_RST_TONE2 8'h80
`define HMT_RST_DIODE 8'h70
`define HMT_RST_BATCTL 8'h00
`define HMT_RST_HY_HI 8'h4B
`define HMT_RST_OV_HI 8'h50
`define HMT_RST_LO 1'h0

// ==========================================
// field masks and positions
`define HMT_MASK_BANK 8'h87
`define HMT_MASK_TONE2 8'hB9
`define HMT_MASK_DIODE 8'h70
`define HMT_MASK_BATCTL 8'hEF
`define HMT_TONE_GATE 7
`define HMT_FLT_HI 4
`define HMT_FLT_LO 3
`define HMT_CFG_MODE 1
`define HMT_CFG_STOP 0
`define HMT_CNT_MAX 3'h4

`endif

// >>> hw/hmt_pkg.sv
// types shared by the monitor bank and its bench
package hmt_pkg;

	// ==========================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hmt_bus_s;

	typedef struct packed {
		logic aux_temp;
		logic case_open;
		logic aux_fan;
		logic analog_input_one;
	} hmt_alarm_s;

	typedef struct packed {
		logic valid;
		logic [8:0] value;
	} hmt_sample_s;

	// ==========================================
	// state
	typedef struct packed {
		logic [8:0] temp;
		logic [8:0] hyst;
		logic [8:0] ovt;
		logic [1:0] fault_code;
		logic int_mode;
		logic stop;
		logic [2:0] cnt;
		logic alert;
		logic armed;
	} hmt_ch_s;

	typedef struct packed {
		logic [7:0] bank_sel;
		logic [7:0] tone2;
		logic [7:0] diode;
		logic [7:0] batctl;
		logic [7:0] vbat;
		logic [7:0] rdata;
		logic [2:0] model;
		logic tone;
		logic ovt_any;
		hmt_ch_s [1:0] ch;
	} hmt_state_s;

endpackage

// >>> verification/hmt_regs_monitor.sv
// port checker for the monitor register bank
`timescale 1ns/1ps
module hmt_regs_monitor (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire hmt_pkg::hmt_bus_s bus_in,
	input wire hmt_pkg::hmt_alarm_s alarm_src_in,
	input wire hmt_pkg::hmt_sample_s [1:0] temp_sample_in,
	input wire logic [7:0] rdata_out,
	input wire logic alarm_tone_output_out,
	input wire logic [1:0] chan_alert_out,
	input wire logic [1:0] chan_stop_out,
	input wire logic [2:0] sensor_diode_out,
	input wire logic [2:0] diode_model_out,
	input wire logic [2:0] fan_div_msb_out,
	input wire logic vbat_enable_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic w5d;
	assign w5d = bus_in.wr && bus_in.addr == 8'h5D;
	// ==========================================
	// properties
	property p_tone; alarm_tone_output_out |-> $past(alarm_src_in) != 4'h0; endproperty
	property p_model; (diode_model_out & ~sensor_diode_out) == 3'h0; endproperty
	property p_sens; !$stable(sensor_diode_out) |-> $past(w5d); endproperty
	property p_fan; !$stable(fan_div_msb_out) |-> $past(w5d); endproperty
	property p_vbat; $rose(vbat_enable_out) |-> $past(w5d && bus_in.wdata[0]); endproperty
	// read data must never leak outside the cycle after a read
	property p_rdat; rdata_out != 8'h00 |-> $past(bus_in.rd); endproperty
	property p_stop; !$stable(chan_stop_out) |-> $past(bus_in.wr && bus_in.addr == 8'h52); endproperty
	property p_trip; $rose(chan_alert_out[0]) |-> $past(temp_sample_in[0].valid && !chan_stop_out[0]); endproperty
	a_tone: assert property (p_tone) else $error("tone without source");
	a_model: assert property (p_model) else $error("diode model without diode sensing");
	a_sens: assert property (p_sens) else $error("sensor type changed without write");
	a_fan: assert property (p_fan) else $error("fan divisor changed without write");
	a_vbat: assert property (p_vbat) else $error("battery enable without write");
	a_rdat: assert property (p_rdat) else $error("read data without read");
	a_stop: assert property (p_stop) else $error("stop changed without write");
	a_trip: assert property (p_trip) else $error("alert without running sample");
	c_tone: cover property (alarm_tone_output_out);
	c_alert: cover property ($rose(chan_alert_out[1]));
	c_vbat: cover property ($rose(vbat_enable_out));
endmodule // hmt_regs_monitor

bind hmt_regs hmt_regs_monitor hmt_regs_monitor_i (.clk_in, .rstn_in, .bus_in, .alarm_src_in,
	.temp_sample_in, .rdata_out, .alarm_tone_output_out, .chan_alert_out, .chan_stop_out,
	.sensor_diode_out, .diode_model_out, .fan_div_msb_out, .vbat_enable_out);

// >>> verification/hmt_regs_tb.sv
// self-checking bench for the monitor register bank
`timescale 1ns/1ps
module hmt_regs_tb;
	localparam logic [7:0] ID = 8'h5A; // arbitrary identity value
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	hmt_pkg::hmt_bus_s bus_in = '0;
	hmt_pkg::hmt_alarm_s alarm_src_in = '0;
	hmt_pkg::hmt_sample_s [1:0] temp_sample_in = '0;
	logic [7:0] vbat_sample_in = 8'hA5;
	logic vbat_cycle_done_in = 1'b0;
	logic [7:0] rdata_out, vbat_reading_out;
	logic alarm_tone_output_out, overtemp_alert_out, vbat_enable_out;
	logic [1:0] chan_alert_out, chan_stop_out;
	logic [2:0] sensor_diode_out, diode_model_out, fan_div_msb_out;
	logic [7:0] en [4] = '{8'h01, 8'h08, 8'h10, 8'h20};
	logic [7:0] rv [5] = '{8'h00, 8'h4B, 8'h00, 8'h50, 8'h00};
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 clk_in = ~clk_in;
	hmt_regs #(.CHIP_IDENTITY(ID)) hmt_regs_i (.clk_in, .rstn_in, .bus_in, .alarm_src_in,
		.temp_sample_in, .vbat_sample_in, .vbat_cycle_done_in, .rdata_out, .alarm_tone_output_out,
		.overtemp_alert_out, .chan_alert_out, .chan_stop_out, .sensor_diode_out, .diode_model_out,
		.fan_div_msb_out, .vbat_enable_out, .vbat_reading_out);
	// ==========================================
	// tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_in.addr <= a;
		bus_in.wdata <= d;
		bus_in.wr <= 1'b1;
		@(posedge clk_in);
		bus_in.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		bus_in.addr <= a;
		bus_in.rd <= 1'b1;
		@(posedge clk_in);
		bus_in.rd <= 1'b0;
		#1 chk("rdata", e, rdata_out);
	endtask
	task automatic smp(input int c, input logic [8:0] v);
		@(posedge clk_in);
		temp_sample_in[c] <= {1'b1, v};
		@(posedge clk_in);
		temp_sample_in[c].valid <= 1'b0;
		#1;
	endtask
	task automatic bat(input logic [7:0] e);
		@(posedge clk_in);
		vbat_cycle_done_in <= 1'b1;
		@(posedge clk_in);
		vbat_cycle_done_in <= 1'b0;
		#1 chk("vbat", e, vbat_reading_out);
	endtask
	// sources settle one cycle before the tone is looked at
	task automatic tone(input logic [7:0] t, input logic [3:0] s, input logic e);
		wr(8'h57, t);
		@(posedge clk_in);
		alarm_src_in <= s;
		@(posedge clk_in);
		#1 chk("tone", {7'h00, e}, {7'h00, alarm_tone_output_out});
	endtask
	task automatic wrap_up;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			wrap_up;
		end
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(8'h4E, 8'h80);
		rd(8'h57, 8'h80);
		rd(8'h59, 8'h70);
		rd(8'h5D, 8'h00);
		bat(8'h00);
		wr(8'h58, 8'hFF);
		rd(8'h58, ID);
		wr(8'h5D, 8'hFF);
		rd(8'h5D, 8'hEF);
		chk("sensor", 8'h07, {5'h00, sensor_diode_out});
		chk("model", 8'h07, {5'h00, diode_model_out});
		chk("fan", 8'h07, {5'h00, fan_div_msb_out});
		chk("vben", 8'h01, {7'h00, vbat_enable_out});
		bat(8'hA5);
		wr(8'h59, 8'h00);
		chk("model", 8'h00, {5'h00, diode_model_out});
		wr(8'h59, 8'hFF);
		wr(8'h5D, 8'h02);
		chk("model", 8'h01, {5'h00, diode_model_out});
		for (int i = 0; i < 4; i++) begin
			tone(8'h80 | en[i], 4'h1 << i, 1'b1);
			tone(en[i], 4'h1 << i, 1'b0);
			tone(8'h80 | en[i], ~(4'h1 << i), 1'b0);
		end
		for (int b = 1; b < 3; b++) begin
			wr(8'h4E, 8'(b));
			foreach (rv[j]) rd(8'(j + 'h52), rv[j]);
		end
		wr(8'h4E, 8'hFF);
		rd(8'h4E, 8'h87);
		rd(8'h53, 8'h00);
		wr(8'h4E, 8'h01);
		wr(8'h52, 8'hFF);
		rd(8'h52, 8'h1B);
		wr(8'h52, 8'h08);
		smp(0, 9'h0A3);
		smp(0, 9'h0A0);
		smp(0, 9'h0A3);
		chk("alert", 8'h00, {6'h00, chan_alert_out});
		smp(0, 9'h0A3);
		chk("alert", 8'h01, {6'h00, chan_alert_out});
		rd(8'h50, 8'h51);
		rd(8'h51, 8'h80);
		smp(0, 9'h096);
		chk("alert", 8'h01, {6'h00, chan_alert_out});
		smp(0, 9'h095);
		chk("alert", 8'h00, {6'h00, chan_alert_out});
		wr(8'h52, 8'h01);
		smp(0, 9'h0A3);
		chk("stop", 8'h01, {6'h00, chan_stop_out});
		chk("alert", 8'h00, {6'h00, chan_alert_out});
		wr(8'h55, 8'hFF);
		rd(8'h55, 8'hFF);
		wr(8'h54, 8'hFF);
		rd(8'h54, 8'h80);
		wr(8'h4E, 8'h02);
		wr(8'h52, 8'h02);
		smp(1, 9'h0A3);
		smp(1, 9'h090);
		chk("alert", 8'h02, {6'h00, chan_alert_out});
		chk("any", 8'h01, {7'h00, overtemp_alert_out});
		rd(8'h52, 8'h02);
		chk("alert", 8'h00, {6'h00, chan_alert_out});
		wrap_up;
	end
endmodule // hmt_regs_tb
